// >>> rtl/isa_host_memory_window_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - four I/O bytes at switch-selected base
// - offset 0 bit 7 gates SRAM host access
// - offset 0 bit 6 disables controller register access
// - first 256 bytes reach controller when enabled
// - offset 0 bits 3..0 select low-mode page
// - offset 1 bits 7..5 route interrupt line
// - high mode: select bits place 256K block
// - low mode: select bits plus bit 0 place window
// - offset 2 bit 7 selects high linear mode
// - low mode window within second 512K
// - high mode block within C00000..FFFFFF
// - controller always uses flat SRAM addresses
// - offset 2 bit 6 selects zero wait states
// - offset 2 bit 5 enables 16-bit transfers
// - offset 2 bit 4 sets interrupt drive style
// - status bit 5 low when interrupt pending
// - status bit 4 low while board reset
// - status bit 3 reports 16-bit slot
// - any write to offset 3 resets board
// - controller runs from its own oscillator
module isa_host_memory_window_ctrl #(
	parameter int WAIT_CYCLES = window_ctrl_pkg::WAIT_CYC,
	parameter int RESET_CYCLES = window_ctrl_pkg::RESET_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:2] io_base_sw,
	input wire window_ctrl_pkg::host_bus_s host_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe_n,
	output logic mem16_out,
	output logic mem16_oe_n,
	output logic chrdy_out,
	output logic chrdy_oe_n,
	output logic [6:0] irq_out,
	output logic [6:0] irq_oe_n,
	input wire logic slot_width_sense,
	input wire logic serial_irq_pending_n,
	input wire logic osc_16m,
	output logic sc_clk,
	output logic sc_reset,
	input wire window_ctrl_pkg::mem_req_s sc_req,
	input wire logic [15:0] sram_rdata,
	output window_ctrl_pkg::mem_req_s sram_req
);
	import window_ctrl_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic io_hit(input logic [23:0] a, input logic [9:2] sw);
		io_hit = (a[9:2] == sw) && (a[15:10] == 6'h00);
	endfunction

	function automatic logic is_write_edge(input logic now_n, input logic was_n);
		is_write_edge = was_n && !now_n;
	endfunction

	function automatic logic [2:0] irq_index(input logic [2:0] route);
		irq_index = route - 3'b001;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] access_page, next_access_page;
	logic [7:0] irq_base, next_irq_base;
	logic [7:0] bus_mode, next_bus_mode;
	logic [15:0] rst_cnt, next_rst_cnt;
	logic slot16, next_slot16;
	logic slot_taken, next_slot_taken;
	logic iow_was_n, memr_was_n, memw_was_n;
	cycle_e cyc, next_cyc;
	logic [15:0] wait_cnt, next_wait_cnt;
	logic [15:0] next_data_out;
	logic next_data_oe_n;
	mem_req_s next_sram_req;
	logic next_mem16_oe_n, next_chrdy_oe_n;
	logic [6:0] next_irq_out, next_irq_oe_n;
	logic host_rd_issued, next_host_rd_issued;

	logic [1:0] io_ofs;
	logic io_sel, io_wr;
	logic mem_hit, sc_window, mem_start;
	logic [17:0] host_ofs;
	logic board_in_reset;

	// i/o decode of the four register bytes
	assign io_ofs = host_in.addr[1:0];
	assign io_sel = io_hit(host_in.addr, io_base_sw);
	assign io_wr = io_sel && is_write_edge(host_in.iow_n, iow_was_n);
	assign board_in_reset = (rst_cnt != 16'h0000);

	// controller clocked straight from its oscillator, not the host clock
	assign sc_clk = osc_16m;

	// ----------------------------------------
	// memory window decode
	// ----------------------------------------
	always_comb begin
		host_ofs = host_in.addr[17:0];
		mem_hit = 1'b0;
		if (bus_mode[B_LINEAR]) begin
			// whole block in top quarter, bit 0 of base ignored
			mem_hit = (host_in.addr[23:22] == HIGH_TOP_BITS)
				&& (host_in.addr[21:18] == irq_base[4:1]);
			host_ofs = host_in.addr[17:0];
		end else begin
			mem_hit = (host_in.addr[23:20] == LOW_TOP_NIBBLE) && host_in.addr[19]
				&& (host_in.addr[18:14] == irq_base[4:0]);
			host_ofs = {access_page[3:0], host_in.addr[PAGE_AW-1:0]};
		end
		mem_hit = mem_hit && access_page[B_SRAM_GATE];
		sc_window = !access_page[B_SC_DISABLE]
			&& (host_ofs < 18'(SC_REG_BYTES));
		mem_start = mem_hit && (is_write_edge(host_in.memr_n, memr_was_n)
			|| is_write_edge(host_in.memw_n, memw_was_n));
	end

	// ----------------------------------------
	// control registers and board reset
	// ----------------------------------------
	always_comb begin
		next_access_page = access_page;
		next_irq_base = irq_base;
		next_bus_mode = bus_mode;
		next_rst_cnt = board_in_reset ? rst_cnt - 16'h0001 : rst_cnt;
		next_slot16 = slot16;
		next_slot_taken = 1'b1;
		// strap sampled once, on the first edge after reset
		if (!slot_taken) begin
			next_slot16 = slot_width_sense;
		end
		// register writes on the falling edge of the write strobe
		if (io_wr) begin
			unique case (io_ofs)
				OFS_ACCESS_PAGE: next_access_page = host_in.data[7:0] & MASK_ACCESS_PAGE;
				OFS_IRQ_BASE: next_irq_base = host_in.data[7:0];
				OFS_BUS_MODE: next_bus_mode = host_in.data[7:0] & MASK_BUS_MODE;
				OFS_STATUS: begin
					// any value resets the card and clears its setup
					next_rst_cnt = 16'(RESET_CYCLES);
					next_access_page = CTRL_RESET;
					next_irq_base = CTRL_RESET;
					next_bus_mode = CTRL_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			access_page <= CTRL_RESET;
			irq_base <= CTRL_RESET;
			bus_mode <= CTRL_RESET;
			rst_cnt <= 16'h0000;
			slot16 <= 1'b0;
			slot_taken <= 1'b0;
			sc_reset <= 1'b1;
		end else begin
			access_page <= next_access_page;
			irq_base <= next_irq_base;
			bus_mode <= next_bus_mode;
			rst_cnt <= next_rst_cnt;
			slot16 <= next_slot16;
			slot_taken <= next_slot_taken;
			sc_reset <= (next_rst_cnt != 16'h0000);
		end
	end

	// ----------------------------------------
	// host cycle sequencing
	// ----------------------------------------
	always_comb begin
		next_cyc = cyc;
		next_wait_cnt = wait_cnt;
		unique case (cyc)
			CYC_IDLE: begin
				// memory cycle start, with or without wait states
				if (mem_start && bus_mode[B_ZERO_WAIT]) begin
					next_cyc = CYC_RUN;
				end else if (mem_start) begin
					next_cyc = CYC_WAIT;
					next_wait_cnt = 16'(WAIT_CYCLES);
				end
			end
			CYC_WAIT: begin
				// count down the inserted wait states
				next_wait_cnt = wait_cnt - 16'h0001;
				if (wait_cnt == 16'h0001) begin
					next_cyc = CYC_RUN;
				end
			end
			CYC_RUN: begin
				// cycle ends once both strobes are back high
				if (host_in.memr_n && host_in.memw_n) begin
					next_cyc = CYC_IDLE;
				end
			end
			default: next_cyc = CYC_IDLE;
		endcase
	end

	// ----------------------------------------
	// bus outputs and SRAM requests
	// ----------------------------------------
	always_comb begin
		logic host_busy;
		logic wide;
		logic [2:0] irq_idx;
		host_busy = (cyc != CYC_IDLE);
		wide = bus_mode[B_WIDE] && slot16;
		irq_idx = irq_index(irq_base[7:5]);
		next_data_out = host_data_out;
		next_data_oe_n = 1'b1;
		if (io_sel && !host_in.ior_n) begin
			next_data_oe_n = 1'b0;
			unique case (io_ofs)
				OFS_ACCESS_PAGE: next_data_out = {8'h00, access_page};
				OFS_STATUS: next_data_out = {8'h00, 2'b00, serial_irq_pending_n,
					!board_in_reset, slot16, 3'b000};
				OFS_IRQ_BASE: next_data_out = 16'h0000;
				OFS_BUS_MODE: next_data_out = 16'h0000;
			endcase
		end else if (cyc == CYC_RUN && host_rd_issued && !host_in.memr_n) begin
			// only once the registered SRAM read has been answered
			next_data_oe_n = 1'b0;
			next_data_out = sram_rdata;
		end
		// controller owns SRAM while host is not in a cycle, with flat addresses
		next_sram_req = sc_req;
		next_sram_req.sc_sel = 1'b0;
		next_host_rd_issued = 1'b0;
		if (host_busy && mem_hit) begin
			next_host_rd_issued = (cyc == CYC_RUN) && !host_in.memr_n;
			next_sram_req.sc_sel = sc_window;
			next_sram_req.sram_sel = !sc_window;
			next_sram_req.addr = host_ofs;
			next_sram_req.rd = (cyc == CYC_RUN) && !host_in.memr_n;
			next_sram_req.wr = (cyc == CYC_RUN) && !host_in.memw_n;
			next_sram_req.wdata = host_in.data;
			// narrow operation only touches the addressed byte lane
			next_sram_req.be = wide ? {!host_in.sbhe_n, !host_in.addr[0]}
				: {host_in.addr[0], !host_in.addr[0]};
		end
		next_mem16_oe_n = !(mem_hit && wide);
		// not ready from the start edge to the end of the countdown
		next_chrdy_oe_n = !(mem_start && !bus_mode[B_ZERO_WAIT])
			&& (cyc != CYC_WAIT);
		// route the interrupt to the selected line
		next_irq_out = 7'h00;
		next_irq_oe_n = 7'h7F;
		if (irq_base[7:5] != 3'b000) begin
			if (bus_mode[B_IRQ_STYLE]) begin
				// standard drive: line held, high while pending
				next_irq_oe_n[irq_idx] = 1'b0;
				next_irq_out[irq_idx] = !serial_irq_pending_n;
			end else begin
				// shareable: pull low only while pending
				next_irq_oe_n[irq_idx] = serial_irq_pending_n;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc <= CYC_IDLE;
			wait_cnt <= 16'h0000;
			iow_was_n <= 1'b1;
			memr_was_n <= 1'b1;
			memw_was_n <= 1'b1;
			host_data_out <= 16'h0000;
			host_data_oe_n <= 1'b1;
			sram_req <= '0;
			mem16_oe_n <= 1'b1;
			chrdy_oe_n <= 1'b1;
			irq_out <= 7'h00;
			irq_oe_n <= 7'h7F;
			host_rd_issued <= 1'b0;
		end else begin
			cyc <= next_cyc;
			wait_cnt <= next_wait_cnt;
			iow_was_n <= host_in.iow_n;
			memr_was_n <= host_in.memr_n;
			memw_was_n <= host_in.memw_n;
			host_data_out <= next_data_out;
			host_data_oe_n <= next_data_oe_n;
			sram_req <= next_sram_req;
			mem16_oe_n <= next_mem16_oe_n;
			chrdy_oe_n <= next_chrdy_oe_n;
			irq_out <= next_irq_out;
			irq_oe_n <= next_irq_oe_n;
			host_rd_issued <= next_host_rd_issued;
		end
	end

	// open-drain pins only ever pull low
	assign mem16_out = 1'b0;
	assign chrdy_out = 1'b0;
endmodule
`default_nettype wire

// >>> inc/window_ctrl_pkg.sv
package window_ctrl_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [1:0] OFS_ACCESS_PAGE = 2'h0;
	localparam logic [1:0] OFS_IRQ_BASE = 2'h1;
	localparam logic [1:0] OFS_BUS_MODE = 2'h2;
	localparam logic [1:0] OFS_STATUS = 2'h3;
	localparam int IO_SPAN = 4;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_SRAM_GATE = 7;
	localparam int B_SC_DISABLE = 6;
	localparam int B_LINEAR = 7;
	localparam int B_ZERO_WAIT = 6;
	localparam int B_WIDE = 5;
	localparam int B_IRQ_STYLE = 4;
	localparam int B_PENDING_N = 5;
	localparam int B_RST_INACTIVE = 4;
	localparam int B_SLOT16 = 3;
	localparam logic [7:0] MASK_ACCESS_PAGE = 8'hCF;
	localparam logic [7:0] MASK_BUS_MODE = 8'hF0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ----------------------------------------
	// memory map
	// ----------------------------------------
	localparam int SRAM_AW = 18;
	localparam int PAGE_AW = 14;
	localparam int SC_REG_BYTES = 256;
	localparam logic [3:0] LOW_TOP_NIBBLE = 4'h0;
	localparam logic [1:0] HIGH_TOP_BITS = 2'h3;
	localparam int IRQ_LINES = 7;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int WAIT_NS = 120;
	localparam int RESET_NS = 1000;
	localparam int WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CYC_IDLE = 3'b001,
		CYC_WAIT = 3'b010,
		CYC_RUN = 3'b100
	} cycle_e;
	typedef struct packed {
		logic [23:0] addr;
		logic ior_n;
		logic iow_n;
		logic memr_n;
		logic memw_n;
		logic sbhe_n;
		logic [15:0] data;
	} host_bus_s;
	typedef struct packed {
		logic sram_sel;
		logic sc_sel;
		logic rd;
		logic wr;
		logic [1:0] be;
		logic [17:0] addr;
		logic [15:0] wdata;
	} mem_req_s;
endpackage

// >>> tb/window_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host port checks
// ----
module window_ctrl_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:2] io_base_sw,
	input wire window_ctrl_pkg::host_bus_s host_in,
	input wire logic [15:0] host_data_out,
	input wire logic host_data_oe_n,
	input wire logic chrdy_oe_n,
	input wire logic [6:0] irq_out,
	input wire logic [6:0] irq_oe_n,
	input wire logic serial_irq_pending_n,
	input wire logic sc_reset
);
	import window_ctrl_pkg::*;
	wire logic hit;
	wire logic st;
	// decode of the four i/o bytes
	assign hit = host_in.addr[9:2] == io_base_sw && host_in.addr[15:10] == 6'h00;
	assign st = hit && host_in.addr[1:0] == OFS_STATUS;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// read, reset, irq and wait relations
	a_read_drive: assert property ($fell(host_in.ior_n) && hit |=> !host_data_oe_n)
		else $error("io read not driven");
	a_read_release: assert property (host_in.ior_n && host_in.memr_n
		&& $past(host_in.ior_n) && $past(host_in.memr_n) |=> host_data_oe_n)
		else $error("data bus held");
	a_upper_zero: assert property ($fell(host_in.ior_n) && hit |=> host_data_out[15:8] == 8'h00)
		else $error("upper byte not zero");
	a_pend_status: assert property ($fell(host_in.ior_n) && st
		|=> host_data_out[B_PENDING_N] == $past(serial_irq_pending_n))
		else $error("pending bit wrong");
	a_board_reset: assert property ($fell(host_in.iow_n) && st |=> sc_reset [*2])
		else $error("board reset missing");
	a_irq_quiet: assert property (serial_irq_pending_n && $past(serial_irq_pending_n)
		|=> irq_out == 7'h00) else $error("irq raised while idle");
	a_irq_single: assert property ($onehot0(~irq_oe_n) && $onehot0(irq_out))
		else $error("more than one irq line");
	a_wait_bound: assert property ($fell(chrdy_oe_n) |-> ##[1:100] chrdy_oe_n)
		else $error("wait state too long");
endmodule
bind isa_host_memory_window_ctrl window_ctrl_asserts window_ctrl_asserts_i (.clk(clk),
	.sys_rst(sys_rst), .io_base_sw(io_base_sw), .host_in(host_in),
	.host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
	.chrdy_oe_n(chrdy_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
	.serial_irq_pending_n(serial_irq_pending_n), .sc_reset(sc_reset));
`default_nettype wire

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// isa host side
// ----
module host_bus_model (
	input wire logic clk,
	input wire logic [9:2] io_base,
	output window_ctrl_pkg::host_bus_s bus,
	input wire logic [15:0] rd_data,
	input wire logic rd_oe_n,
	input wire logic rdy_oe_n
);
	import window_ctrl_pkg::*;
	// idle bus, all strobes high
	initial bus = {24'h00_0000, 5'h1F, 16'h0000};
	// one i/o cycle, strobe held to the answer edge
	task automatic io(input logic wr, input logic [1:0] ofs, input logic [7:0] wd,
		output logic [15:0] rd);
		@(negedge clk);
		bus.addr = {14'h0000, io_base, ofs};
		bus.data = {8'h00, wd};
		bus.iow_n = !wr;
		bus.ior_n = wr;
		@(posedge clk);
		if (!wr) @(posedge clk);
		#1 rd = rd_data;
		@(negedge clk);
		bus.iow_n = 1'b1;
		bus.ior_n = 1'b1;
		bus.data = ~bus.data;
	endtask
	// memory read, held until data stands and ready
	task automatic mem_rd(input logic [23:0] a, output logic [15:0] rd, output logic ok, w);
		@(negedge clk);
		bus.addr = a;
		bus.memr_n = 1'b0;
		ok = 1'b0;
		w = 1'b0;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(posedge clk);
			#1 w = w | !rdy_oe_n;
			ok = !rd_oe_n && rdy_oe_n;
		end
		rd = rd_data;
		@(negedge clk);
		bus.memr_n = 1'b1;
		bus.addr = ~a;
	endtask
endmodule
`default_nettype wire

// >>> tb/isa_host_memory_window_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module isa_host_memory_window_ctrl_tb_top;
	import window_ctrl_pkg::*;
	logic clk, sys_rst, pend_n, oe_n, rdy_oe_n, sc_reset, last_sc, m16_n, last_w16;
	logic [15:0] dout;
	logic [6:0] irq, irq_oe_n;
	logic [17:0] last_a;
	logic [9:2] sw = 8'hC0;
	int err_total, checks;
	host_bus_s bus;
	mem_req_s sreq;
	isa_host_memory_window_ctrl #(.WAIT_CYCLES(2), .RESET_CYCLES(16)) isa_host_memory_window_ctrl_i (
		.clk(clk), .sys_rst(sys_rst), .io_base_sw(sw), .host_in(bus), .host_data_out(dout),
		.host_data_oe_n(oe_n), .mem16_out(), .mem16_oe_n(m16_n), .chrdy_out(),
		.chrdy_oe_n(rdy_oe_n),
		.irq_out(irq), .irq_oe_n(irq_oe_n), .slot_width_sense(1'b1), .serial_irq_pending_n(pend_n),
		.osc_16m(clk), .sc_clk(), .sc_reset(sc_reset), .sc_req('0),
		.sram_rdata(sreq.addr[15:0] ^ 16'hA5A5), .sram_req(sreq));
	host_bus_model host_bus_model_i (.clk(clk), .io_base(sw), .bus(bus), .rd_data(dout),
		.rd_oe_n(oe_n), .rdy_oe_n(rdy_oe_n));
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// last sram request seen
	always @(posedge clk) if (sreq.rd) begin
		last_a <= sreq.addr;
		last_sc <= sreq.sc_sel;
		last_w16 <= m16_n;
	end
	task automatic chk(input logic [17:0] g, e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic io(input int w, input int o, input logic [7:0] d);
		logic [15:0] v;
		host_bus_model_i.io(w[0], o[1:0], d, v);
		if (w == 0) chk(18'(v), 18'(d));
	endtask
	task automatic mr(input logic [23:0] a, input logic [17:0] ea, input logic ok_e, w_e, sc_e);
		logic [15:0] v;
		logic ok, w;
		host_bus_model_i.mem_rd(a, v, ok, w);
		chk(18'(ok), 18'(ok_e));
		if (ok_e) begin
			chk(last_a, ea);
			chk(18'(v[7:0]), 18'(ea[7:0] ^ 8'hA5));
			chk(18'(w), 18'(w_e));
			chk(18'(last_sc), 18'(sc_e));
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#80000;
		err_total++;
		stop_test();
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		pend_n = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		io(0, 0, 8'h00);
		io(0, 1, 8'h00);
		io(0, 2, 8'h00);
		io(0, 3, 8'h38);
		io(1, 0, 8'hFF);
		io(0, 0, 8'hCF);
		pend_n = 1'b0;
		io(0, 3, 8'h18);
		io(1, 2, 8'h10);
		for (int i = 0; i < 8; i++) begin
			io(1, 1, 8'(i << 5));
			repeat (2) @(negedge clk);
			chk(18'(irq_oe_n), i ? 18'(7'h7F ^ (7'h01 << (i - 1))) : 18'h0_007F);
			chk(18'(irq), i ? 18'(7'h01 << (i - 1)) : 18'h0_0000);
		end
		io(1, 2, 8'h00);
		repeat (2) @(negedge clk);
		chk(18'(irq_oe_n), 18'h0_003F);
		pend_n = 1'b1;
		io(1, 2, 8'h40);
		io(1, 1, 8'h0B);
		io(1, 0, 8'hC5);
		mr(24'h0A_C124, 18'h1_4124, 1'b1, 1'b0, 1'b0);
		io(1, 2, 8'hC0);
		mr(24'hD6_0456, 18'h2_0456, 1'b1, 1'b0, 1'b0);
		chk(18'(last_w16), 18'h0_0001);
		io(1, 2, 8'hE0);
		mr(24'hD6_0456, 18'h2_0456, 1'b1, 1'b0, 1'b0);
		chk(18'(last_w16), 18'h0_0000);
		io(1, 2, 8'h80);
		io(1, 0, 8'h85);
		mr(24'hD4_0010, 18'h0_0010, 1'b1, 1'b1, 1'b1);
		io(1, 0, 8'h05);
		mr(24'hD4_0010, 18'h0_0010, 1'b0, 1'b0, 1'b0);
		io(1, 3, 8'h00);
		io(0, 3, 8'h28);
		io(0, 0, 8'h00);
		repeat (20) @(negedge clk);
		io(0, 3, 8'h38);
		stop_test();
	end
endmodule
`default_nettype wire
